// >>> rtl/canxm_pkg.sv
// Purpose: Shared constants and types of the transceiver mode and wake control.
// Assumes: core_clk at 20 MHz; register port with one-cycle read latency.
// Notes: Times are kept in ns; cycle counts derive from them.
package canxm_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	// Enabling settle time after Normal mode is reached (least time, rounded up)
	localparam int unsigned EN_TIME_NS = 50000;
	localparam int unsigned EN_CYC = (EN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Wake phase filter (least, rounded up) and limit (longest, rounded down)
	localparam int unsigned WAKE_MIN_NS = 500;
	localparam int unsigned WAKE_MIN_CYC = (WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WAKE_MAX_NS = 1000000;
	localparam int unsigned WAKE_MAX_CYC = WAKE_MAX_NS / CLK_PERIOD_NS;
	// Transmit dominant time-out (least time, rounded up)
	localparam int unsigned TX_TO_NS = 2000000;
	localparam int unsigned TX_TO_CYC = (TX_TO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam logic [7:0] REG_MODE = 8'h00;
	localparam logic [7:0] REG_STATE = 8'h04;
	localparam logic [7:0] REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] REG_IRQ_CLR = 8'h0C;
	localparam logic [7:0] REG_IRQ_EN = 8'h10;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// Interrupt status layout
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_WAKE_BIT = 0;
	localparam int unsigned IRQ_TXTO_BIT = 1;
	// State register layout
	localparam int unsigned ST_MODE_LSB = 0;
	localparam int unsigned ST_ARMED_BIT = 2;
	localparam int unsigned ST_HOLD_BIT = 3;
	localparam int unsigned ST_EN_DONE_BIT = 4;
	localparam int unsigned ST_TO_BIT = 5;
	localparam int unsigned ST_ACTIVE_BIT = 6;

	typedef enum logic [1:0] {
		MODE_OFF = 2'h0,
		MODE_WAKE = 2'h1,
		MODE_RXONLY = 2'h2,
		MODE_NORMAL = 2'h3
	} canxm_mode_t;

	typedef enum logic [2:0] {
		CHIP_NORMAL = 3'h0,
		CHIP_STOP = 3'h1,
		CHIP_SLEEP = 3'h2,
		CHIP_RESTART = 3'h3,
		CHIP_FAILSAFE = 3'h4
	} canxm_chip_t;

	// Wake filter states, Gray along idle, dominant, recessive, dominant
	typedef enum logic [1:0] {
		WK_IDLE = 2'h0,
		WK_DOM1 = 2'h1,
		WK_REC = 2'h3,
		WK_DOM2 = 2'h2
	} canxm_wk_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} canxm_bus_t;
endpackage : canxm_pkg

// >>> rtl/canxm_ctrl.sv
// Purpose: Transceiver mode control, transmit enabling, receive signalling and bus wake filter.
// Assumes: All inputs synchronous to core_clk; bus_dominant is the differential receiver verdict.
// Notes: Registers on a plain port; read data appear the cycle after the read strobe.
// Functional notes
// - After reset the transceiver mode is Off and stays so until software writes another mode or chip Fail-Safe is entered.
// - Off can be selected in every chip mode and ignores all bus wake activity.
// - Normal mode comes only from a register write and works only in chip Normal or Stop mode.
// - In Normal mode a low transmit input drives dominant and a high one recessive.
// - A low already present at the end of enabling is not sent; sending starts with the next low.
// - In Normal mode the receive output shows the bus state from the differential receiver.
// - Receive Only mode in chip Normal or Stop keeps reception and never drives the bus.
// - Wake Capable is selectable in Stop, Sleep, Restart, Normal and forced on Fail-Safe entry.
// - A detected wake pattern holds the receive output low until the mode is changed.
// - A wake pattern is dominant, recessive, dominant, each phase between the two wake times.
// - The mode comes from the mode bits and also follows transitions forced by chip mode changes.
// - Wake Capable reads as 01 and still reads so after a wake while receive is held low.
// - Wake detection rearms on re-entering Wake Capable or on chip Stop or Fail-Safe entry.
// - A transmit low past the time-out disables the driver, flags a failure, and recovers on high.
//
// Design decisions made here: the address map and the strobed register port.
module canxm_ctrl #(
	parameter int unsigned WAKE_MAX_CYC = canxm_pkg::WAKE_MAX_CYC,
	parameter int unsigned TX_TO_CYC = canxm_pkg::TX_TO_CYC
) (
	input wire logic core_clk,
	input wire logic nrst,
	input wire canxm_pkg::canxm_bus_t bus_req,
	output logic [31:0] rdata,
	input wire logic [2:0] chip_mode,
	input wire logic tx_serial_in,
	input wire logic bus_dominant,
	output logic rx_out,
	output logic drv_en,
	output logic drv_dominant,
	output logic bias_en,
	output logic irq
);
	localparam int unsigned WK_W = $clog2(WAKE_MAX_CYC + 1);
	localparam int unsigned TO_W = $clog2(TX_TO_CYC + 1);
	localparam int unsigned EN_W = $clog2(canxm_pkg::EN_CYC + 1);

	canxm_pkg::canxm_mode_t mode_q, mode_d, mode_prev_q;
	canxm_pkg::canxm_chip_t chip, chip_prev_q;
	logic [canxm_pkg::IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_en_q, irq_en_d, irq_clr;
	logic [31:0] rdata_d;
	logic irq_d;
	logic chip_ok, active_tx, active_rx, wake_evt, to_evt, rearm;
	logic [EN_W-1:0] en_cnt_q, en_cnt_d;
	logic en_done_q, en_done_d, tx_armed_q, tx_armed_d;
	logic [TO_W-1:0] to_cnt_q, to_cnt_d;
	logic to_active_q, to_active_d;
	logic drv_en_d, drv_dom_d, bias_en_d, rx_d;
	canxm_pkg::canxm_wk_t wk_q, wk_d;
	logic [WK_W-1:0] wk_cnt_q, wk_cnt_d;
	logic wk_armed_q, wk_armed_d, hold_q, hold_d;
	logic ph_ok, ph_over;

	// Chip mode decode and gating of driver and bias
	assign chip = canxm_pkg::canxm_chip_t'(chip_mode);
	assign chip_ok = (chip == canxm_pkg::CHIP_NORMAL) || (chip == canxm_pkg::CHIP_STOP);
	assign active_tx = (mode_q == canxm_pkg::MODE_NORMAL) && chip_ok;
	assign active_rx = ((mode_q == canxm_pkg::MODE_NORMAL) || (mode_q == canxm_pkg::MODE_RXONLY)) && chip_ok;
	assign irq_clr = (bus_req.wr && bus_req.addr == canxm_pkg::REG_IRQ_CLR) ? bus_req.wdata[canxm_pkg::IRQ_W-1:0] : '0;

	// Register file: mode, interrupt status and enable, read data
	always_comb begin
		mode_d = mode_q;
		irq_en_d = irq_en_q;
		rdata_d = 32'h0;
		if (bus_req.wr && bus_req.addr == canxm_pkg::REG_MODE) begin
			mode_d = canxm_pkg::canxm_mode_t'(bus_req.wdata[1:0]);
		end
		if (chip == canxm_pkg::CHIP_FAILSAFE && chip_prev_q != canxm_pkg::CHIP_FAILSAFE) begin
			mode_d = canxm_pkg::MODE_WAKE;
		end
		if (bus_req.wr && bus_req.addr == canxm_pkg::REG_IRQ_EN) begin
			irq_en_d = bus_req.wdata[canxm_pkg::IRQ_W-1:0];
		end
		// Set wins over a clear in the same cycle
		irq_stat_d = irq_stat_q & ~irq_clr;
		irq_stat_d[canxm_pkg::IRQ_WAKE_BIT] = irq_stat_d[canxm_pkg::IRQ_WAKE_BIT] | wake_evt;
		irq_stat_d[canxm_pkg::IRQ_TXTO_BIT] = irq_stat_d[canxm_pkg::IRQ_TXTO_BIT] | to_evt;
		irq_d = |(irq_stat_q & irq_en_q);
		if (bus_req.rd) begin
			case (bus_req.addr)
				canxm_pkg::REG_MODE: rdata_d[1:0] = mode_q;
				canxm_pkg::REG_STATE: begin
					rdata_d[canxm_pkg::ST_MODE_LSB +: 2] = mode_q;
					rdata_d[canxm_pkg::ST_ARMED_BIT] = wk_armed_q;
					rdata_d[canxm_pkg::ST_HOLD_BIT] = hold_q;
					rdata_d[canxm_pkg::ST_EN_DONE_BIT] = en_done_q;
					rdata_d[canxm_pkg::ST_TO_BIT] = to_active_q;
					rdata_d[canxm_pkg::ST_ACTIVE_BIT] = active_tx;
				end
				canxm_pkg::REG_IRQ_STAT: rdata_d[canxm_pkg::IRQ_W-1:0] = irq_stat_q;
				canxm_pkg::REG_IRQ_EN: rdata_d[canxm_pkg::IRQ_W-1:0] = irq_en_q;
				default: rdata_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			mode_q <= canxm_pkg::canxm_mode_t'(canxm_pkg::MODE_RESET);
			chip_prev_q <= canxm_pkg::CHIP_NORMAL;
			irq_stat_q <= '0;
			irq_en_q <= '0;
			rdata <= 32'h0;
			irq <= 1'b0;
		end else begin
			mode_q <= mode_d;
			chip_prev_q <= chip;
			irq_stat_q <= irq_stat_d;
			irq_en_q <= irq_en_d;
			rdata <= rdata_d;
			irq <= irq_d;
		end
	end

	// Transmit enabling, time-out and pin outputs
	always_comb begin
		en_cnt_d = en_cnt_q;
		en_done_d = en_done_q;
		tx_armed_d = tx_armed_q;
		to_cnt_d = to_cnt_q;
		to_active_d = to_active_q;
		to_evt = 1'b0;
		if (!active_tx) begin
			en_cnt_d = '0;
			en_done_d = 1'b0;
			tx_armed_d = 1'b0;
			to_cnt_d = '0;
			to_active_d = 1'b0;
		end else begin
			if (!en_done_q) begin
				en_cnt_d = en_cnt_q + 1'b1;
				en_done_d = (en_cnt_q == EN_W'(canxm_pkg::EN_CYC - 1));
			end
			// A stale low at the end of enabling waits for a high first
			if (en_done_q && tx_serial_in) begin
				tx_armed_d = 1'b1;
			end
			if (tx_serial_in) begin
				to_cnt_d = '0;
				to_active_d = 1'b0;
			end else if (tx_armed_q && !to_active_q) begin
				to_cnt_d = to_cnt_q + 1'b1;
				if (to_cnt_q == TO_W'(TX_TO_CYC - 1)) begin
					to_active_d = 1'b1;
					to_evt = 1'b1;
				end
			end
		end
		// Driver drops in the same cycle as the time-out flag sets
		drv_en_d = active_tx && !to_active_d;
		drv_dom_d = active_tx && en_done_q && tx_armed_q && !to_active_d && !tx_serial_in;
		bias_en_d = active_rx;
		if (hold_q) begin
			rx_d = 1'b0;
		end else if (active_rx) begin
			rx_d = !bus_dominant;
		end else begin
			rx_d = 1'b1;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			en_cnt_q <= '0;
			en_done_q <= 1'b0;
			tx_armed_q <= 1'b0;
			to_cnt_q <= '0;
			to_active_q <= 1'b0;
			drv_en <= 1'b0;
			drv_dominant <= 1'b0;
			bias_en <= 1'b0;
			rx_out <= 1'b1;
		end else begin
			en_cnt_q <= en_cnt_d;
			en_done_q <= en_done_d;
			tx_armed_q <= tx_armed_d;
			to_cnt_q <= to_cnt_d;
			to_active_q <= to_active_d;
			drv_en <= drv_en_d;
			drv_dominant <= drv_dom_d;
			bias_en <= bias_en_d;
			rx_out <= rx_d;
		end
	end

	// Wake pattern filter, arming and receive hold
	assign ph_ok = wk_cnt_q > WK_W'(canxm_pkg::WAKE_MIN_CYC);
	assign ph_over = wk_cnt_q >= WK_W'(WAKE_MAX_CYC);
	assign rearm = (mode_q == canxm_pkg::MODE_WAKE && mode_prev_q != canxm_pkg::MODE_WAKE) ||
		(chip != chip_prev_q && (chip == canxm_pkg::CHIP_STOP || chip == canxm_pkg::CHIP_FAILSAFE));

	always_comb begin
		wk_d = wk_q;
		wk_cnt_d = wk_cnt_q + 1'b1;
		wake_evt = 1'b0;
		wk_armed_d = wk_armed_q | rearm;
		hold_d = hold_q && (mode_d == canxm_pkg::MODE_WAKE);
		if (mode_q != canxm_pkg::MODE_WAKE || !wk_armed_q) begin
			wk_d = canxm_pkg::WK_IDLE;
			wk_cnt_d = '0;
		end else if (ph_over) begin
			wk_d = canxm_pkg::WK_IDLE;
			wk_cnt_d = '0;
		end else begin
			case (wk_q)
				canxm_pkg::WK_IDLE: begin
					wk_cnt_d = WK_W'(1);
					if (bus_dominant) begin
						wk_d = canxm_pkg::WK_DOM1;
					end
				end
				canxm_pkg::WK_DOM1: begin
					if (!bus_dominant) begin
						wk_d = ph_ok ? canxm_pkg::WK_REC : canxm_pkg::WK_IDLE;
						wk_cnt_d = WK_W'(1);
					end
				end
				canxm_pkg::WK_REC: begin
					if (bus_dominant) begin
						wk_d = ph_ok ? canxm_pkg::WK_DOM2 : canxm_pkg::WK_DOM1;
						wk_cnt_d = WK_W'(1);
					end
				end
				canxm_pkg::WK_DOM2: begin
					if (!bus_dominant) begin
						wk_d = canxm_pkg::WK_IDLE;
						wk_cnt_d = '0;
						if (ph_ok) begin
							wake_evt = 1'b1;
							wk_armed_d = rearm;
							hold_d = (mode_d == canxm_pkg::MODE_WAKE);
						end
					end
				end
				default: begin
					wk_d = canxm_pkg::WK_IDLE;
					wk_cnt_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			wk_q <= canxm_pkg::WK_IDLE;
			wk_cnt_q <= '0;
			wk_armed_q <= 1'b0;
			hold_q <= 1'b0;
			mode_prev_q <= canxm_pkg::MODE_OFF;
		end else begin
			wk_q <= wk_d;
			wk_cnt_q <= wk_cnt_d;
			wk_armed_q <= wk_armed_d;
			hold_q <= hold_d;
			mode_prev_q <= mode_q;
		end
	end

	// Checks on the block's own behaviour
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	a_reset_mode_off: assert property ($rose(nrst) |-> mode_q == canxm_pkg::MODE_OFF)
		else $error("mode not off after reset");
	a_off_no_wake: assert property (mode_q == canxm_pkg::MODE_OFF |-> !wake_evt ##1 !$rose(hold_q))
		else $error("wake signalled in off mode");
	a_drive_needs_chip: assert property (drv_en |-> $past(chip_ok) && $past(mode_q) == canxm_pkg::MODE_NORMAL)
		else $error("driver enabled in forbidden mode");
	a_dominant_follows_tx: assert property (drv_dominant |-> !$past(tx_serial_in) && drv_en)
		else $error("dominant without low transmit input");
	a_stale_low_blocked: assert property (($rose(en_done_q) && !tx_serial_in) |=> !drv_dominant)
		else $error("stale low forwarded after enabling");
	a_rx_follows_bus: assert property ((active_rx && !hold_q) |=> rx_out == !$past(bus_dominant))
		else $error("receive output not following bus");
	a_rxonly_silent: assert property ((mode_q == canxm_pkg::MODE_RXONLY) |=> !drv_dominant && !drv_en)
		else $error("bus driven in receive only mode");
	a_failsafe_wake: assert property ($rose(chip == canxm_pkg::CHIP_FAILSAFE) |=> mode_q == canxm_pkg::MODE_WAKE)
		else $error("fail-safe entry did not force wake capable");
	a_wake_holds_rx: assert property (wake_evt ##1 mode_q == canxm_pkg::MODE_WAKE |=> !rx_out)
		else $error("receive output not held low after wake");
	a_wake_phase_limit: assert property (wk_cnt_q <= WK_W'(WAKE_MAX_CYC))
		else $error("wake phase counter over limit");
	a_timeout_flags: assert property (to_evt |=> irq_stat_q[canxm_pkg::IRQ_TXTO_BIT] && !drv_en ##1
		(!drv_en || $past(tx_serial_in)))
		else $error("time-out did not flag or disable");
	a_mode_reads_wake: assert property (hold_q |-> mode_q == canxm_pkg::MODE_WAKE)
		else $error("mode field not wake while held");

	// Gating of driver and bias by transceiver and chip mode
	a_chip_forbids_drive: assert property (!chip_ok |=> !bias_en && !drv_en)
		else $error("driver or bias on in forbidden chip mode");
	a_off_no_drive: assert property (mode_q == canxm_pkg::MODE_OFF |=> !drv_en && !bias_en)
		else $error("driver or bias on in off mode");
	a_wake_mode_no_drive: assert property (mode_q == canxm_pkg::MODE_WAKE |=> !drv_en && !bias_en)
		else $error("driver or bias on in wake capable mode");
	a_rx_path_bias: assert property (active_rx |=> bias_en)
		else $error("bias off with receive path active");
	a_rx_idle_high: assert property ((!active_rx && !hold_q) |=> rx_out)
		else $error("receive output not idle high");
	a_write_sets_mode: assert property ((bus_req.wr && bus_req.addr == canxm_pkg::REG_MODE &&
		!(chip == canxm_pkg::CHIP_FAILSAFE && chip_prev_q != canxm_pkg::CHIP_FAILSAFE)) |=>
		mode_q == $past(bus_req.wdata[1:0]))
		else $error("mode write not taken");

	// Transmit enabling, level following and time-out recovery
	a_enable_wait: assert property (drv_dominant |-> $past(en_done_q))
		else $error("dominant sent before enabling done");
	a_enable_length: assert property ($rose(en_done_q) |-> $past(en_cnt_q) == EN_W'(canxm_pkg::EN_CYC - 1))
		else $error("enabling time not counted in full");
	a_recessive_follows_tx: assert property ((drv_en && tx_serial_in) |=> !drv_dominant)
		else $error("dominant with high transmit input");
	a_tx_recovers: assert property ((active_tx && to_active_q && tx_serial_in) |=> !to_active_q && drv_en)
		else $error("transmitter not restored after time-out");

	// Wake filter and rearming
	a_wake_sets_flag: assert property (wake_evt |=> irq_stat_q[canxm_pkg::IRQ_WAKE_BIT])
		else $error("wake event not flagged");
	a_wake_needs_arm: assert property (wake_evt |-> wk_armed_q && mode_q == canxm_pkg::MODE_WAKE)
		else $error("wake signalled while not armed");
	a_short_dom_rejected: assert property ((wk_q == canxm_pkg::WK_DOM1 && !bus_dominant && !ph_ok &&
		!ph_over && mode_q == canxm_pkg::MODE_WAKE && wk_armed_q) |=> wk_q == canxm_pkg::WK_IDLE)
		else $error("short dominant phase accepted");
	a_phase_over_idle: assert property ((ph_over && mode_q == canxm_pkg::MODE_WAKE && wk_armed_q) |=>
		wk_q == canxm_pkg::WK_IDLE)
		else $error("over-long phase not rejected");
	a_toggle_rearms: assert property ((mode_q == canxm_pkg::MODE_WAKE && $past(mode_q) != canxm_pkg::MODE_WAKE) |=>
		wk_armed_q)
		else $error("wake not rearmed on mode toggle");
	a_stop_rearms: assert property (($changed(chip_mode) && chip == canxm_pkg::CHIP_STOP) |=> wk_armed_q)
		else $error("wake not rearmed on stop entry");
	a_failsafe_rearms: assert property ($rose(chip == canxm_pkg::CHIP_FAILSAFE) |=> wk_armed_q)
		else $error("wake not rearmed on fail-safe entry");

	c_wake_seen: cover property (wake_evt);
	c_timeout_seen: cover property (to_evt ##[1:100] drv_en);
	c_frame_sent: cover property ($rose(en_done_q) ##[1:200] drv_dominant);
	c_rearm_by_stop: cover property (rearm && chip == canxm_pkg::CHIP_STOP);
	c_rxonly_rx: cover property (mode_q == canxm_pkg::MODE_RXONLY && !rx_out);
endmodule : canxm_ctrl

// >>> testbench/canxm_partner.sv
// Purpose: Protocol controller model on the transmit and receive pins.
// Assumes: Changes its transmit level just after a core_clk rising edge.
// Notes: Idles recessive; the bench orders early lows on purpose.
module canxm_partner (
	input wire logic core_clk,
	input wire logic rx_out,
	output logic tx_serial_in
);
	timeunit 1ns;
	timeprecision 1ns;
	// Recessive from time zero until the bench asks for a level
	initial begin
		tx_serial_in = 1'b1;
	end
	// Drive one level from the next edge for n cycles; rx_out is left to the bench
	task automatic send(input logic lvl, input int n);
		@(posedge core_clk);
		tx_serial_in <= lvl;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : send
endmodule : canxm_partner

// >>> testbench/canxm_ctrl_tb.sv
// Purpose: Self-checking bench of the transceiver mode and wake control.
// Assumes: Register port with one-cycle read data; small wake and time-out limits.
// Notes: Another bus node is modelled by node_dom, wired with our own driver.
module canxm_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic nrst = 1'b0;
	canxm_pkg::canxm_bus_t bus_req = '0;
	logic [2:0] chip_mode = 3'h0;
	logic node_dom = 1'b0;
	logic [31:0] rdata;
	logic tx_serial_in, rx_out, drv_en, drv_dominant, bias_en, irq, bus_dominant;
	int n_mismatch = 0;
	int n_checks = 0;
	// Clock and bus wire
	always #25 core_clk = ~core_clk;
	assign bus_dominant = (drv_en & drv_dominant) | node_dom;
	canxm_ctrl #(.WAKE_MAX_CYC(200), .TX_TO_CYC(100)) u_canxm_ctrl (
		.core_clk(core_clk), .nrst(nrst), .bus_req(bus_req), .rdata(rdata), .chip_mode(chip_mode),
		.tx_serial_in(tx_serial_in), .bus_dominant(bus_dominant), .rx_out(rx_out), .drv_en(drv_en),
		.drv_dominant(drv_dominant), .bias_en(bias_en), .irq(irq)
	);
	canxm_partner u_canxm_partner (.core_clk(core_clk), .rx_out(rx_out), .tx_serial_in(tx_serial_in));
	task automatic end_sim();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim
	task automatic chk_bit(input logic got, input logic exp, input string what);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %b", $time, what, got);
		end
	endtask : chk_bit
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: read got %h want %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.wdata <= d;
		bus_req.wr <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1;
		chk_word(rdata, exp);
	endtask : rd
	task automatic node(input logic lvl, input int n);
		@(posedge core_clk);
		node_dom <= lvl;
		repeat (n) @(posedge core_clk);
		#1;
	endtask : node
	// Dominant, recessive, dominant, then recessive idle
	task automatic bus_wake_pattern(input int d1, input int r, input int d2);
		node(1'b1, d1);
		node(1'b0, r);
		node(1'b1, d2);
		node(1'b0, 10);
	endtask : bus_wake_pattern
	task automatic chip(input logic [2:0] m);
		@(posedge core_clk);
		chip_mode <= m;
		cyc(3);
	endtask : chip
	// Main test sequence
	initial begin
		repeat (5) @(posedge core_clk);
		nrst <= 1'b1;
		cyc(1);
		chk_bit(rx_out, 1'b1, "rx idle");
		chk_bit(bias_en, 1'b0, "bias off");
		rd(canxm_pkg::REG_MODE, 32'h0);
		rd(canxm_pkg::REG_IRQ_EN, 32'h0);
		rd(8'hFC, 32'h0);
		bus_wake_pattern(20, 20, 20);
		chk_bit(rx_out, 1'b1, "off ignores wake");
		rd(canxm_pkg::REG_IRQ_STAT, 32'h0);
		for (int m = 2; m < 4; m++) begin
			for (int t = 2; t < 4; t++) begin
				chip(m[2:0]);
				wr(canxm_pkg::REG_MODE, 32'(t));
				cyc(3);
				chk_bit(drv_en, 1'b0, "driver in bad chip mode");
				chk_bit(bias_en, 1'b0, "bias in bad chip mode");
			end
		end
		u_canxm_partner.send(1'b0, 1);
		chip(canxm_pkg::CHIP_NORMAL);
		cyc(500);
		chk_bit(bias_en, 1'b1, "bias in normal");
		chk_bit(drv_dominant, 1'b0, "low during enabling");
		cyc(600);
		chk_bit(drv_dominant, 1'b0, "stale low after enabling");
		rd(canxm_pkg::REG_STATE, 32'h53);
		u_canxm_partner.send(1'b1, 3);
		u_canxm_partner.send(1'b0, 3);
		chk_bit(drv_dominant, 1'b1, "dominant sent");
		chk_bit(rx_out, 1'b0, "rx dominant");
		u_canxm_partner.send(1'b1, 3);
		chk_bit(drv_dominant, 1'b0, "recessive sent");
		chk_bit(rx_out, 1'b1, "rx recessive");
		u_canxm_partner.send(1'b0, 130);
		chk_bit(drv_en, 1'b0, "driver off after time-out");
		rd(canxm_pkg::REG_IRQ_STAT, 32'h2);
		u_canxm_partner.send(1'b1, 3);
		chk_bit(drv_en, 1'b1, "driver back");
		rd(canxm_pkg::REG_MODE, 32'h3);
		wr(canxm_pkg::REG_IRQ_CLR, 32'h3);
		wr(canxm_pkg::REG_MODE, 32'h2);
		u_canxm_partner.send(1'b0, 5);
		chk_bit(drv_en, 1'b0, "no driver in receive only");
		chk_bit(bias_en, 1'b1, "bias in receive only");
		node(1'b1, 3);
		chk_bit(rx_out, 1'b0, "receive only rx");
		node(1'b0, 3);
		u_canxm_partner.send(1'b1, 1);
		wr(canxm_pkg::REG_IRQ_EN, 32'h1);
		wr(canxm_pkg::REG_MODE, 32'h1);
		bus_wake_pattern(20, 20, 20);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h1);
		chk_bit(irq, 1'b1, "wake irq");
		chk_bit(rx_out, 1'b0, "wake holds rx");
		rd(canxm_pkg::REG_MODE, 32'h1);
		rd(canxm_pkg::REG_STATE, 32'h9);
		wr(canxm_pkg::REG_IRQ_CLR, 32'h1);
		bus_wake_pattern(20, 20, 20);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h0);
		chk_bit(irq, 1'b0, "irq cleared");
		chk_bit(rx_out, 1'b0, "rx still held");
		wr(canxm_pkg::REG_MODE, 32'h0);
		cyc(3);
		chk_bit(rx_out, 1'b1, "rx released");
		wr(canxm_pkg::REG_MODE, 32'h1);
		rd(canxm_pkg::REG_STATE, 32'h5);
		bus_wake_pattern(20, 250, 20);
		cyc(210);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h0);
		bus_wake_pattern(20, 20, 20);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h1);
		wr(canxm_pkg::REG_IRQ_CLR, 32'h1);
		chip(canxm_pkg::CHIP_STOP);
		bus_wake_pattern(20, 20, 20);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h1);
		wr(canxm_pkg::REG_MODE, 32'h0);
		rd(canxm_pkg::REG_MODE, 32'h0);
		chip(canxm_pkg::CHIP_FAILSAFE);
		rd(canxm_pkg::REG_MODE, 32'h1);
		wr(canxm_pkg::REG_IRQ_CLR, 32'h1);
		bus_wake_pattern(20, 20, 20);
		rd(canxm_pkg::REG_IRQ_STAT, 32'h1);
		end_sim();
	end
	// Watchdog well beyond the expected run
	initial begin
		#(20000 * 50);
		n_mismatch++;
		end_sim();
	end
endmodule : canxm_ctrl_tb
